// ---- hdl/sweep_pkg.sv ----
package sweep_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned PROC_TIME_US = 50;
  localparam int unsigned PROC_CYCLES = PROC_TIME_US * CLK_MHZ;
  localparam int unsigned LEAD_TIME_US = 50;
  localparam int unsigned LEAD_CYCLES = LEAD_TIME_US * CLK_MHZ;
  localparam int unsigned TAIL_TIME_US = 50;
  localparam int unsigned TAIL_CYCLES = TAIL_TIME_US * CLK_MHZ;
  // Dwell and timer are programmed in microseconds
  localparam int unsigned DWELL_MIN_US = 100;
  localparam int unsigned DWELL_MAX_US = 500000000;
  localparam int unsigned TIMER_MIN_US = 500;
  localparam int unsigned TIMER_MAX_US = 1000000000;
  localparam int unsigned US_CYCLES = CLK_MHZ;
  localparam logic [31:0] DWELL_RESET = 32'h0000_03e8;
  localparam logic [31:0] TIMER_RESET = 32'h0000_03e8;
  localparam int unsigned TABLE_DEPTH = 16;
  localparam int unsigned PTR_W = 4;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] DWELL_OFS = 8'h08;
  localparam logic [7:0] TIMER_OFS = 8'h0c;
  localparam logic [7:0] POINTS_OFS = 8'h10;
  localparam logic [7:0] CMD_OFS = 8'h14;
  localparam logic [7:0] TABLE_OFS = 8'h40;

  // CTRL fields
  localparam int unsigned SWP_SRC_LSB = 0;
  localparam int unsigned PNT_SRC_LSB = 4;
  localparam int unsigned EXT_POL_BIT = 8;
  localparam int unsigned TABLE_MODE_BIT = 9;
  localparam int unsigned ROUTE_SETTLED_BIT = 10;
  localparam int unsigned SRQ_EN_BIT = 11;
  localparam int unsigned CONT_BIT = 12;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // STATUS fields
  localparam int unsigned SETTLED_BIT = 0;
  localparam int unsigned READY_BIT = 1;
  localparam int unsigned SETTLE_EDGE_BIT = 2;
  localparam int unsigned SWEEPING_BIT = 3;
  // CMD fields
  localparam int unsigned CMD_INIT_BIT = 0;
  localparam int unsigned CMD_TRG_BIT = 1;
  localparam int unsigned CMD_ABORT_BIT = 2;
  localparam int unsigned CMD_CLR_BIT = 3;

  typedef enum logic [2:0] {
    SRC_FREE = 3'b000,
    SRC_KEY = 3'b001,
    SRC_BUS = 3'b010,
    SRC_EXT = 3'b011,
    SRC_TIMER = 3'b100
  } trig_src_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ARMED = 3'b001,
    ST_WAIT_PT = 3'b010,
    ST_PROC = 3'b011,
    ST_LEAD = 3'b100,
    ST_SETTLE = 3'b101,
    ST_TAIL = 3'b110
  } seq_state_type;

  // Trigger event group fed to both selectors
  typedef struct packed {
    logic key;
    logic bus;
    logic ext;
    logic timer;
  } trig_events_type;

endpackage : sweep_pkg

// ---- hdl/pin_sync.sv ----
`timescale 1ns/100ps

// Three-stage synchroniser; a level counts once stages two and three agree.
module pin_sync
  import sweep_pkg::*;
(
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic ce, // Clock enable
  input wire logic pin, // Asynchronous pin
  output logic level, // Filtered level
  output logic rise, // One-cycle pulse on filtered rise
  output logic fall // One-cycle pulse on filtered fall
);

  logic [2:0] sync_q;
  logic level_q;
  wire agree = sync_q[1] == sync_q[2];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync_q <= 3'h0;
      level_q <= 1'b0;
    end
    else if (ce)
    begin
      sync_q <= {sync_q[1:0], pin};
      if (agree)
        level_q <= sync_q[2];
    end
  end

  assign level = level_q;
  assign rise = ce && agree && sync_q[2] && !level_q;
  assign fall = ce && agree && !sync_q[2] && level_q;

endmodule : pin_sync

// ---- hdl/sweep_point_trigger_sequencer.sv ----
`timescale 1ns/100ps

// Operation
// - Separate sweep and point source selectors, each free, key, bus, external, timer.
// - Free-run sweep source starts the sweep as soon as ready.
// - Free-run point source holds each point for the dwell, then advances.
// - One dwell for stepped sweeps; per-entry dwell from the table otherwise.
// - Dwell accepts 100 us up to 500 s; outside values are clamped.
// - A key press starts the sweep or advances one point.
// - A bus trigger command starts the sweep or advances one point.
// - External input triggers on a selectable polarity, high or low true.
// - Periodic timer 0.5 ms to 1000 s triggers regardless of settling.
// - About 50 us after an external point trigger, handshake output drops.
// - 50 us later the settled line drops and the point change starts.
// - Settled rises when settled; handshake output rises 50 us later.
// - New point triggers are taken only once the handshake output is high.
// - When enabled, a service request is raised once the output settles.
// - Status holds a settled bit and a sticky record of its rising edge.
// - Settled may be routed to the handshake output connector.
// - Status bit 3 reads one while sweeping, zero after the sweep ends.
module sweep_point_trigger_sequencer
  import sweep_pkg::*;
(
  input wire logic aclk, // 125 MHz clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic [31:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [31:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic trigger_key_n, // Front-panel key, low while pressed
  input wire logic point_trigger_input, // External trigger pin
  input wire logic settle_done, // Point change has settled (same clock)
  output logic point_change, // Pulse: apply next point's settings
  output logic [15:0] point_index, // Current point number
  output logic source_settled, // Settled indicator
  output logic ready_handshake_output, // Handshake output connector
  output logic service_request // Service request to the instrument bus
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] clamp_us(input logic [31:0] v, input logic [31:0] lo,
                                           input logic [31:0] hi);
    clamp_us = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp_us

  function automatic logic src_hit(input trig_src_type s, input trig_events_type e);
    case (s)
      SRC_FREE: src_hit = 1'b1;
      SRC_KEY: src_hit = e.key;
      SRC_BUS: src_hit = e.bus;
      SRC_EXT: src_hit = e.ext;
      SRC_TIMER: src_hit = e.timer;
      default: src_hit = 1'b0;
    endcase
  endfunction : src_hit

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [31:0] dwell_q;
  logic [31:0] timer_q;
  logic [15:0] points_q;
  logic [31:0] table_q [TABLE_DEPTH];
  logic settle_edge_q;
  logic bus_trg_q, init_q, abort_q;
  logic aw_done_q, w_done_q, bvalid_q, rvalid_q;
  logic [31:0] awaddr_q, wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic bresp_err_q, rresp_err_q;

  seq_state_type state_q;
  logic [31:0] cnt_q;
  logic [15:0] idx_q;
  logic settled_q, hs_q, srq_q, chg_q;

  wire trig_src_type sweep_src = trig_src_type'(ctrl_q[SWP_SRC_LSB +: 3]);
  wire trig_src_type point_src = trig_src_type'(ctrl_q[PNT_SRC_LSB +: 3]);
  wire ext_pol = ctrl_q[EXT_POL_BIT];
  wire table_mode = ctrl_q[TABLE_MODE_BIT];
  wire route_settled = ctrl_q[ROUTE_SETTLED_BIT];
  wire srq_en = ctrl_q[SRQ_EN_BIT];
  wire cont_mode = ctrl_q[CONT_BIT];

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  wire aw_take = s_axi_awvalid && !aw_done_q && !bvalid_q;
  wire w_take = s_axi_wvalid && !w_done_q && !bvalid_q;
  wire [31:0] wr_addr = aw_take ? s_axi_awaddr : awaddr_q;
  wire [31:0] wr_data = w_take ? s_axi_wdata : wdata_q;
  wire [3:0] wr_strb = w_take ? s_axi_wstrb : wstrb_q;
  wire wr_go = ce && (aw_take || aw_done_q) && (w_take || w_done_q) && !bvalid_q;
  wire [7:0] wr_ofs = wr_addr[7:0];
  wire wr_tbl = wr_ofs >= TABLE_OFS && wr_ofs < TABLE_OFS + 8'(4 * TABLE_DEPTH);
  wire [PTR_W-1:0] wr_tidx = wr_ofs[2 +: PTR_W];
  wire wr_ok = wr_tbl || wr_ofs == CTRL_OFS || wr_ofs == DWELL_OFS ||
    wr_ofs == TIMER_OFS || wr_ofs == POINTS_OFS || wr_ofs == CMD_OFS || wr_ofs == STATUS_OFS;
  wire cmd_wr = wr_go && wr_ofs == CMD_OFS && wr_strb[0];

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    for (int b = 0; b < 4; b++)
      merge[8*b +: 8] = st[b] ? nw[8*b +: 8] : old[8*b +: 8];
  endfunction : merge

  assign s_axi_awready = ce && !aw_done_q && !bvalid_q;
  assign s_axi_wready = ce && !w_done_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_err_q ? 2'h2 : 2'h0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_done_q <= 1'b0;
      w_done_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_err_q <= 1'b0;
      awaddr_q <= 32'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end
    else if (ce)
    begin
      if (aw_take)
        awaddr_q <= s_axi_awaddr;
      if (w_take)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      aw_done_q <= (aw_done_q || aw_take) && !wr_go;
      w_done_q <= (w_done_q || w_take) && !wr_go;
      if (wr_go)
      begin
        bvalid_q <= 1'b1;
        bresp_err_q <= !wr_ok;
      end
      else if (s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= CTRL_RESET;
      dwell_q <= DWELL_RESET;
      timer_q <= TIMER_RESET;
      points_q <= 16'h0001;
    end
    else if (wr_go)
    begin
      if (wr_ofs == CTRL_OFS)
        ctrl_q <= merge(ctrl_q, wr_data, wr_strb);
      if (wr_ofs == DWELL_OFS)
        dwell_q <= merge(dwell_q, wr_data, wr_strb);
      if (wr_ofs == TIMER_OFS)
        timer_q <= merge(timer_q, wr_data, wr_strb);
      if (wr_ofs == POINTS_OFS)
        points_q <= 16'(merge({16'h0, points_q}, wr_data, wr_strb));
    end
  end

  always_ff @(posedge aclk)
  begin
    if (wr_go && wr_tbl)
      table_q[wr_tidx] <= merge(table_q[wr_tidx], wr_data, wr_strb);
  end

  // Command strobes are single-cycle pulses taken from the CMD register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bus_trg_q <= 1'b0;
      init_q <= 1'b0;
      abort_q <= 1'b0;
    end
    else if (ce)
    begin
      bus_trg_q <= cmd_wr && wr_data[CMD_TRG_BIT];
      init_q <= cmd_wr && wr_data[CMD_INIT_BIT];
      abort_q <= cmd_wr && wr_data[CMD_ABORT_BIT];
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  wire [7:0] rd_ofs = s_axi_araddr[7:0];
  wire rd_tbl = rd_ofs >= TABLE_OFS && rd_ofs < TABLE_OFS + 8'(4 * TABLE_DEPTH);
  wire sweeping = state_q != ST_IDLE;
  wire [31:0] status_word = {28'h0, sweeping, settle_edge_q, hs_q, settled_q};
  wire rd_take = ce && s_axi_arvalid && !rvalid_q;
  wire [31:0] rd_val =
    rd_tbl ? table_q[rd_ofs[2 +: PTR_W]] :
    rd_ofs == CTRL_OFS ? ctrl_q :
    rd_ofs == STATUS_OFS ? status_word :
    rd_ofs == DWELL_OFS ? dwell_q :
    rd_ofs == TIMER_OFS ? timer_q :
    rd_ofs == POINTS_OFS ? {16'h0, points_q} :
    rd_ofs == CMD_OFS ? 32'h0 : 32'h0;
  wire rd_ok = rd_tbl || rd_ofs == CTRL_OFS || rd_ofs == STATUS_OFS || rd_ofs == DWELL_OFS ||
    rd_ofs == TIMER_OFS || rd_ofs == POINTS_OFS || rd_ofs == CMD_OFS;

  assign s_axi_arready = ce && !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_err_q ? 2'h2 : 2'h0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_err_q <= 1'b0;
    end
    else if (ce)
    begin
      if (rd_take)
      begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_val;
        rresp_err_q <= !rd_ok;
      end
      else if (s_axi_rready)
        rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Trigger sources
  // ----------------------------------------------------------------
  logic ext_rise, ext_fall, key_fall;
  logic [31:0] per_cnt_q, per_us_q;
  logic [7:0] us_cnt_q;

  pin_sync ext_sync (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .pin(point_trigger_input),
    .level(), .rise(ext_rise), .fall(ext_fall)
  );
  pin_sync key_sync (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .pin(trigger_key_n),
    .level(), .rise(), .fall(key_fall)
  );

  wire us_tick = us_cnt_q == 8'(US_CYCLES - 1);
  wire [31:0] period_us = clamp_us(timer_q, 32'(TIMER_MIN_US), 32'(TIMER_MAX_US));
  wire timer_tick = us_tick && per_us_q >= period_us - 32'h1;

  // Periodic timer runs free of the point sequence so settling never stretches it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      us_cnt_q <= 8'h0;
      per_us_q <= 32'h0;
    end
    else if (ce)
    begin
      us_cnt_q <= us_tick ? 8'h0 : us_cnt_q + 8'h1;
      if (us_tick)
        per_us_q <= timer_tick ? 32'h0 : per_us_q + 32'h1;
    end
  end
  assign per_cnt_q = per_us_q;

  trig_events_type ev;
  assign ev.key = key_fall;
  assign ev.bus = bus_trg_q;
  assign ev.ext = ext_pol ? ext_rise : ext_fall;
  assign ev.timer = timer_tick;

  // ----------------------------------------------------------------
  // Point sequencer
  // ----------------------------------------------------------------
  wire [31:0] dwell_raw = table_mode ? table_q[idx_q[PTR_W-1:0]] : dwell_q;
  wire [31:0] dwell_us = clamp_us(dwell_raw, 32'(DWELL_MIN_US), 32'(DWELL_MAX_US));
  wire last_point = idx_q + 16'h1 >= points_q;
  wire point_go = src_hit(point_src, ev);
  wire sweep_go = src_hit(sweep_src, ev);
  logic [31:0] dwell_cnt_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= ST_IDLE;
      cnt_q <= 32'h0;
      dwell_cnt_q <= 32'h0;
      idx_q <= 16'h0;
      settled_q <= 1'b1;
      hs_q <= 1'b1;
      chg_q <= 1'b0;
    end
    else if (ce)
    begin
      chg_q <= 1'b0;
      cnt_q <= cnt_q + 32'h1;
      if (abort_q)
      begin
        state_q <= ST_IDLE;
        settled_q <= 1'b1;
        hs_q <= 1'b1;
      end
      else
        case (state_q)
          ST_IDLE:
            if (init_q || cont_mode)
            begin
              state_q <= ST_ARMED;
              idx_q <= 16'h0;
            end
          ST_ARMED:
            if (sweep_go)
            begin
              state_q <= ST_WAIT_PT;
              dwell_cnt_q <= 32'h0;
            end
          ST_WAIT_PT:
          begin
            if (us_tick)
              dwell_cnt_q <= dwell_cnt_q + 32'h1;
            // Free run waits out the dwell; other sources need an event, taken only here
            if (point_src == SRC_FREE ? dwell_cnt_q >= dwell_us : point_go)
            begin
              state_q <= ST_PROC;
              cnt_q <= 32'h0;
            end
          end
          ST_PROC:
            if (cnt_q >= 32'(PROC_CYCLES - 1))
            begin
              hs_q <= 1'b0;
              state_q <= ST_LEAD;
              cnt_q <= 32'h0;
            end
          ST_LEAD:
            if (cnt_q >= 32'(LEAD_CYCLES - 1))
            begin
              settled_q <= 1'b0;
              chg_q <= 1'b1;
              state_q <= ST_SETTLE;
            end
          ST_SETTLE:
            if (settle_done && !chg_q)
            begin
              settled_q <= 1'b1;
              state_q <= ST_TAIL;
              cnt_q <= 32'h0;
            end
          ST_TAIL:
            if (cnt_q >= 32'(TAIL_CYCLES - 1))
            begin
              hs_q <= 1'b1;
              dwell_cnt_q <= 32'h0;
              if (last_point)
                state_q <= ST_IDLE;
              else
              begin
                idx_q <= idx_q + 16'h1;
                state_q <= ST_WAIT_PT;
              end
            end
          default:
            state_q <= ST_IDLE;
        endcase
    end
  end

  // ----------------------------------------------------------------
  // Settled status and service request
  // ----------------------------------------------------------------
  wire settle_rise = state_q == ST_SETTLE && settle_done && !chg_q && ce && !abort_q;
  wire clr_edge = cmd_wr && wr_data[CMD_CLR_BIT];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      settle_edge_q <= 1'b0;
      srq_q <= 1'b0;
    end
    else if (ce)
    begin
      // A new settle event wins over a clear in the same cycle
      if (settle_rise)
        settle_edge_q <= 1'b1;
      else if (clr_edge)
        settle_edge_q <= 1'b0;
      if (settle_rise && srq_en)
        srq_q <= 1'b1;
      else if (clr_edge || !srq_en)
        srq_q <= 1'b0;
    end
  end

  assign point_change = chg_q;
  assign point_index = idx_q;
  assign source_settled = settled_q;
  assign ready_handshake_output = route_settled ? settled_q : hs_q;
  assign service_request = srq_q;

endmodule : sweep_point_trigger_sequencer

// ---- sim/sweep_chk.sv ----
`timescale 1ns/100ps

module sweep_chk
  import sweep_pkg::*;
(
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, active low
  input wire logic settle_done, // Far side settled
  input wire logic point_change, // Point change pulse
  input wire logic [15:0] point_index, // Point number
  input wire logic source_settled, // Settled indicator
  input wire logic ready_handshake_output, // Handshake output
  input wire logic service_request // Service request
);
  // --------------------
  // Interval counters
  // --------------------
  logic hs_q;
  logic st_q;
  logic [15:0] fall_q;
  logic [15:0] rise_q;
  logic [1:0] pc_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hs_q <= 1'b1;
      st_q <= 1'b1;
      fall_q <= 16'hffff;
      rise_q <= 16'hffff;
      pc_q <= 2'h0;
    end
    else
    begin
      hs_q <= ready_handshake_output;
      st_q <= source_settled;
      if (hs_q && !ready_handshake_output) fall_q <= 16'h0001;
      else if (fall_q != 16'hffff) fall_q <= fall_q + 16'h0001;
      if (!st_q && source_settled) rise_q <= 16'h0001;
      else if (rise_q != 16'hffff) rise_q <= rise_q + 16'h0001;
      if (ready_handshake_output) pc_q <= 2'h0;
      else if (point_change && pc_q != 2'h3) pc_q <= pc_q + 2'h1;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // --------------------
  // Handshake sequence
  // --------------------
  hs_order_a: assert property ($fell(ready_handshake_output) |-> source_settled)
    else $error("handshake fell while not settled");
  lead_time_a: assert property (point_change |-> fall_q == LEAD_CYCLES)
    else $error("point change not one lead time after handshake fall");
  settle_drop_a: assert property (point_change |-> !source_settled && $past(source_settled))
    else $error("settled did not drop with point change");
  settle_rise_a: assert property ($rose(source_settled) |-> $past(settle_done) && !$past(point_change))
    else $error("settled rose without settle done");
  tail_time_a: assert property ($rose(ready_handshake_output) |-> rise_q == TAIL_CYCLES)
    else $error("handshake rise not one tail time after settled");
  accept_gate_a: assert property (point_change |-> !ready_handshake_output)
    else $error("point change while handshake high");
  one_change_a: assert property (pc_q <= 2'h1)
    else $error("second point change in one handshake");
  index_step_a: assert property ($changed(point_index) |->
    point_index == 16'h0 || point_index == $past(point_index) + 16'h0001)
    else $error("point index did not advance by one");
  srq_settled_a: assert property ($rose(service_request) |-> source_settled)
    else $error("service request while not settled");
endmodule : sweep_chk

bind sweep_point_trigger_sequencer sweep_chk chk (.aclk(aclk), .aresetn(aresetn),
  .settle_done(settle_done), .point_change(point_change), .point_index(point_index),
  .source_settled(source_settled), .ready_handshake_output(ready_handshake_output),
  .service_request(service_request));

// ---- sim/controller_model.sv ----
`timescale 1ns/100ps

module controller_model
  import sweep_pkg::*;
#(
  parameter int SETTLE = 40
)
(
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, active low
  input wire logic run, // Trigger after each handshake
  input wire logic low_true, // Pin polarity
  input wire logic noisy, // Early trigger while busy
  input wire logic point_change, // Point change pulse
  input wire logic ready_handshake_output, // Handshake output
  output logic settle_done, // New point settled
  output logic point_trigger_input // Trigger pin
);
  logic [15:0] set_q;
  logic [15:0] gap_q;
  logic [3:0] pulse_q;
  logic run_q;
  logic hs_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      set_q <= 16'h0;
      gap_q <= 16'h0;
      pulse_q <= 4'h0;
      run_q <= 1'b0;
      hs_q <= 1'b1;
    end
    else
    begin
      run_q <= run;
      hs_q <= ready_handshake_output;
      if (point_change) set_q <= 16'(SETTLE);
      else if (set_q != 16'h0) set_q <= set_q - 16'h0001;
      // Measure for 200 cycles after each rise, then trigger again
      if (run && (!run_q || (ready_handshake_output && !hs_q))) gap_q <= 16'd200;
      else if (noisy && hs_q && !ready_handshake_output) gap_q <= 16'd100;
      else if (gap_q != 16'h0) gap_q <= gap_q - 16'h0001;
      if (gap_q == 16'h1 && (run || noisy)) pulse_q <= 4'h8;
      else if (pulse_q != 4'h0) pulse_q <= pulse_q - 4'h1;
    end
  end

  assign settle_done = (set_q == 16'h0) && !point_change;
  assign point_trigger_input = (pulse_q != 4'h0) ^ low_true;
endmodule : controller_model

// ---- sim/testbench.sv ----
`timescale 1ns/100ps

module testbench
  import sweep_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic key_n = 1'b1, run = 1'b0, low_true = 1'b0, noisy = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, settle_done, pin, pchg, settled, hs, srq;
  logic [1:0] bresp, rresp;
  logic [15:0] pidx;
  int bad_count = 0, cmp_count = 0, pc_count = 0;

  always #4 aclk = ~aclk;
  always @(posedge aclk) if (pchg === 1'b1) pc_count++;

  sweep_point_trigger_sequencer dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .trigger_key_n(key_n), .point_trigger_input(pin), .settle_done(settle_done),
    .point_change(pchg), .point_index(pidx), .source_settled(settled),
    .ready_handshake_output(hs), .service_request(srq));

  controller_model far (.aclk(aclk), .aresetn(aresetn), .run(run), .low_true(low_true),
    .noisy(noisy), .point_change(pchg), .ready_handshake_output(hs),
    .settle_done(settle_done), .point_trigger_input(pin));

  // --------------------
  // Shared tasks
  // --------------------
  task automatic results;
    if (bad_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic hang(input string what);
    check(what, 32'h0, 32'h1);
    results();
  endtask : hang

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    awaddr <= {24'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    if (n == 100) hang("write");
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      d = rdata;
      r = rresp;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    if (n == 100) hang("read");
  endtask : rd

  task automatic wait_hs(input logic v, output int n);
    for (n = 0; hs !== v && n < 20000; n++) @(posedge aclk);
    if (hs !== v) hang("handshake");
  endtask : wait_hs

  // Init is written together with the clear bit, which clears the sticky settle record
  task automatic start(input logic [31:0] ctrl);
    wr(CTRL_OFS, ctrl);
    wr(POINTS_OFS, 32'h1);
    wr(CMD_OFS, 32'h9);
  endtask : start

  // One point, c0 cycles already spent since the trigger
  task automatic finish(input string what, input int c0, input logic extra);
    int n;
    int pc0;
    logic [31:0] d;
    logic [1:0] r;
    pc0 = pc_count;
    wait_hs(1'b0, n);
    check(what, 32'((n + c0) inside {[PROC_CYCLES:PROC_CYCLES + 8]}), 32'h1);
    if (extra) wr(CMD_OFS, 32'h2);
    wait_hs(1'b1, n);
    repeat (4) @(posedge aclk);
    check("point changes", pc_count - pc0, 32'h1);
    rd(STATUS_OFS, d, r);
    check("status after point", d, 32'h7);
  endtask : finish

  // --------------------
  // Scenarios
  // --------------------
  task automatic reset_values;
    logic [31:0] d;
    logic [1:0] r;
    rd(STATUS_OFS, d, r);
    check("status at reset", d, 32'h3);
    rd(CTRL_OFS, d, r);
    check("ctrl at reset", d, CTRL_RESET);
    rd(8'h30, d, r);
    check("unmapped resp", {30'h0, r}, 32'h2);
  endtask : reset_values

  task automatic ext_point(input logic lt);
    int n;
    logic [31:0] d;
    logic [1:0] r;
    start(32'h30 | (lt ? 32'h0 : 32'h100));
    low_true <= lt;
    rd(STATUS_OFS, d, r);
    check("sweeping", d & 32'h8, 32'h8);
    noisy <= 1'b1;
    run <= 1'b1;
    for (n = 0; pin !== !lt && n < 400; n++) @(posedge aclk);
    if (pin !== !lt) hang("trigger pin");
    run <= 1'b0;
    finish("ext latency", 0, 1'b0);
    noisy <= 1'b0;
  endtask : ext_point

  task automatic key_point;
    start(32'h10);
    key_n <= 1'b0;
    repeat (10) @(posedge aclk);
    key_n <= 1'b1;
    finish("key latency", 10, 1'b0);
  endtask : key_point

  task automatic bus_point;
    start(32'h820);
    wr(CMD_OFS, 32'h2);
    finish("bus latency", 0, 1'b1);
    check("srq set", {31'h0, srq}, 32'h1);
    wr(CMD_OFS, 32'h8);
    @(posedge aclk);
    check("srq cleared", {31'h0, srq}, 32'h0);
  endtask : bus_point

  task automatic free_point;
    int n;
    wr(DWELL_OFS, 32'h0);
    start(32'h0);
    wait_hs(1'b0, n);
    check("dwell", 32'((n - PROC_CYCLES) inside {[12370:12510]}), 32'h1);
    finish("dwell end", PROC_CYCLES, 1'b0);
  endtask : free_point

  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    reset_values();
    ext_point(1'b0);
    ext_point(1'b1);
    key_point();
    bus_point();
    free_point();
    results();
  end
endmodule : testbench
